// ===== hdl/nand_host_ctrl.sv
`timescale 1ns/100ps
module nand_host_ctrl #(
    parameter int PROG_WAIT  = nand_host_pkg::cycMax(nand_host_pkg::T_PROG_NS),
    parameter int CPROG_WAIT = nand_host_pkg::cycMax(nand_host_pkg::T_CBSY_NS),
    parameter int ERASE_WAIT = nand_host_pkg::cycMax(nand_host_pkg::T_ERASE_NS),
    parameter int RST_WAIT   = nand_host_pkg::cycMax(nand_host_pkg::T_RST_NS)
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  reqValid,
    input  wire nand_host_pkg::req_s   req,
    output logic                       reqReady,
    output logic                       respValid,
    output nand_host_pkg::resp_s       resp,
    input  wire logic                  writeAllow,
    output logic                       chipSelN,
    output logic                       cmdLatch,
    output logic                       addrLatch,
    output logic                       writeStrobeN,
    output logic                       readStrobeN,
    output logic                       writeProtN,
    output logic [15:0]                ioOut,
    output logic                       ioOeN,
    input  wire logic [15:0]           ioIn,
    input  wire logic                  readyBusyN
);

    typedef enum logic [7:0] {
        S_IDLE  = 8'b0000_0001,
        S_SETUP = 8'b0000_0010,
        S_WLOW  = 8'b0000_0100,
        S_WHIGH = 8'b0000_1000,
        S_RSET  = 8'b0001_0000,
        S_RLOW  = 8'b0010_0000,
        S_RHIGH = 8'b0100_0000,
        S_BUSY  = 8'b1000_0000
    } state_e;

    localparam int W = nand_host_pkg::CNT_W;

    state_e                state_reg;
    logic [W-1:0]          cnt_reg;
    logic [W-1:0]          limit_reg;
    logic [15:0]           ioSync;
    logic                  rbLevel;
    logic                  isConfirm;
    logic [7:0]            rqCode;
    logic [W-1:0]          waitNext;
    logic                  refuseNow;
    logic [2:0]            addrIdx_reg;
    logic [15:0]           row_reg;
    logic [15:0]           lastRow_reg;
    logic [2:0]            progCnt_reg;
    logic                  inProg_reg;

    pin_sync #(.W(17)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pinIn ({readyBusyN, ioIn}),
        .level ({rbLevel, ioSync})
    );

    assign rqCode = req.data[7:0];

    // ****************************************
    // host-side checks before a cycle leaves
    // ****************************************
    always_comb begin
        isConfirm = rqCode inside {nand_host_pkg::C_READ2,
            nand_host_pkg::C_CRDRND, nand_host_pkg::C_CRDEND,
            nand_host_pkg::C_PROG2, nand_host_pkg::C_CPROG2,
            nand_host_pkg::C_ERASE2, nand_host_pkg::C_SETFEAT,
            nand_host_pkg::C_GETFEAT, nand_host_pkg::C_RESET};
        refuseNow = 1'b0;
        if (req.kind == nand_host_pkg::K_CMD) begin
            if (!nand_host_pkg::isDefined(rqCode)) begin
                refuseNow = 1'b1;
            end else if (!rbLevel && !nand_host_pkg::isBusyOk(rqCode)) begin
                refuseNow = 1'b1;
            end else if (nand_host_pkg::isWriteMode(rqCode) && !writeAllow) begin
                refuseNow = 1'b1;
            end else if ((rqCode == nand_host_pkg::C_PROG2 ||
                          rqCode == nand_host_pkg::C_CPROG2) &&
                         row_reg == lastRow_reg &&
                         progCnt_reg == 3'(nand_host_pkg::PARTIAL_PROGRAM_LIMIT)) begin
                refuseNow = 1'b1;
            end
        end else if (req.kind == nand_host_pkg::K_DIN && !writeAllow) begin
            refuseNow = 1'b1;
        end
        // longest busy per operation; timeouts round down
        case (rqCode)
            nand_host_pkg::C_READ2:   waitNext = W'(nand_host_pkg::RD_CYC);
            nand_host_pkg::C_CRDRND,
            nand_host_pkg::C_CRDEND:  waitNext = W'(nand_host_pkg::RCBSY_CYC);
            nand_host_pkg::C_PROG2:   waitNext = W'(PROG_WAIT);
            nand_host_pkg::C_CPROG2:  waitNext = W'(CPROG_WAIT);
            nand_host_pkg::C_ERASE2:  waitNext = W'(ERASE_WAIT);
            nand_host_pkg::C_SETFEAT,
            nand_host_pkg::C_GETFEAT: waitNext = W'(nand_host_pkg::FEAT_CYC);
            nand_host_pkg::C_RESET:   waitNext = W'(RST_WAIT);
            default:                  waitNext = '0;
        endcase
    end

    // ****************************************
    // cycle sequencer
    // ****************************************
    // every pin steps from a flop; strobes never move in the setup cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg    <= S_IDLE;
            cnt_reg      <= '0;
            limit_reg    <= '0;
            reqReady     <= 1'b0;
            respValid    <= 1'b0;
            resp         <= '0;
            chipSelN     <= 1'b1;
            cmdLatch     <= 1'b0;
            addrLatch    <= 1'b0;
            writeStrobeN <= 1'b1;
            readStrobeN  <= 1'b1;
            ioOut        <= '0;
            ioOeN        <= 1'b1;
        end else begin
            respValid <= 1'b0;
            reqReady  <= 1'b0;
            cnt_reg   <= cnt_reg + W'(1);
            case (state_reg)
                S_IDLE: begin
                    chipSelN <= 1'b1;
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOeN    <= 1'b1;
                    if (reqValid && !reqReady) begin
                        reqReady <= 1'b1;
                        cnt_reg  <= '0;
                        limit_reg <= isConfirm ? waitNext : '0;
                        resp     <= '0;
                        if (refuseNow) begin
                            resp.refused <= 1'b1;
                            respValid    <= 1'b1;
                        end else if (req.kind == nand_host_pkg::K_DOUT) begin
                            chipSelN  <= 1'b0;
                            state_reg <= S_RSET;
                        end else begin
                            chipSelN  <= 1'b0;
                            cmdLatch  <= (req.kind == nand_host_pkg::K_CMD);
                            addrLatch <= (req.kind == nand_host_pkg::K_ADDR);
                            ioOeN     <= 1'b0;
                            ioOut     <= (req.kind == nand_host_pkg::K_CMD) ?
                                         {8'h00, rqCode} : req.data;
                            state_reg <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    if (cnt_reg >= W'(nand_host_pkg::SETUP_CYC - 1)) begin
                        writeStrobeN <= 1'b0;
                        cnt_reg      <= '0;
                        state_reg    <= S_WLOW;
                    end
                end
                S_WLOW: begin
                    if (cnt_reg >= W'(nand_host_pkg::WP_CYC - 1)) begin
                        writeStrobeN <= 1'b1;
                        cnt_reg      <= '0;
                        state_reg    <= S_WHIGH;
                    end
                end
                S_WHIGH: begin
                    if (limit_reg != '0) begin
                        if (cnt_reg >= W'(nand_host_pkg::WB_CYC - 1)) begin
                            cnt_reg   <= '0;
                            state_reg <= S_BUSY;
                        end
                    end else if (cnt_reg >= W'(nand_host_pkg::WH_CYC - 1)) begin
                        respValid <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_RSET: begin
                    // covers write-to-read turnaround on every read
                    if (cnt_reg >= W'(nand_host_pkg::WHR_CYC - 1)) begin
                        readStrobeN <= 1'b0;
                        cnt_reg     <= '0;
                        state_reg   <= S_RLOW;
                    end
                end
                S_RLOW: begin
                    // access time plus synchroniser latency before sampling
                    if (cnt_reg >= W'(nand_host_pkg::REA_CYC +
                                       nand_host_pkg::SYNC_STAGES)) begin
                        resp.data   <= ioSync;
                        readStrobeN <= 1'b1;
                        cnt_reg     <= '0;
                        state_reg   <= S_RHIGH;
                    end
                end
                S_RHIGH: begin
                    if (cnt_reg >= W'(nand_host_pkg::REH_CYC - 1)) begin
                        respValid <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_BUSY: begin
                    // short refused busies (otp, protected block) end early
                    if (rbLevel) begin
                        respValid <= 1'b1;
                        state_reg <= S_IDLE;
                    end else if (cnt_reg >= limit_reg) begin
                        resp.timeout <= 1'b1;
                        respValid    <= 1'b1;
                        state_reg    <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // write protect and partial program count
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            writeProtN <= 1'b0;
        end else begin
            writeProtN <= writeAllow;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addrIdx_reg <= '0;
            row_reg     <= '0;
            lastRow_reg <= '1;
            progCnt_reg <= '0;
            inProg_reg  <= 1'b0;
        end else if (state_reg == S_IDLE && reqValid && !reqReady &&
                     !refuseNow) begin
            if (req.kind == nand_host_pkg::K_CMD) begin
                addrIdx_reg <= '0;
                if (rqCode == nand_host_pkg::C_PROG1) begin
                    inProg_reg <= 1'b1;
                end else if (rqCode == nand_host_pkg::C_ERASE2) begin
                    progCnt_reg <= '0;
                    inProg_reg  <= 1'b0;
                end else if (rqCode == nand_host_pkg::C_PROG2 ||
                             rqCode == nand_host_pkg::C_CPROG2) begin
                    inProg_reg  <= 1'b0;
                    lastRow_reg <= row_reg;
                    progCnt_reg <= (row_reg == lastRow_reg) ?
                                   progCnt_reg + 3'h1 : 3'h1;
                end
            end else if (req.kind == nand_host_pkg::K_ADDR && inProg_reg) begin
                addrIdx_reg <= addrIdx_reg + 3'h1;
                if (addrIdx_reg >= 3'h2) begin
                    row_reg <= {row_reg[7:0], req.data[7:0]};
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_CMD_PINS: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(writeStrobeN) && cmdLatch |-> !addrLatch && !chipSelN && readStrobeN)
        else $error("command cycle pins wrong");
    AST_ADDR_PINS: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(writeStrobeN) && addrLatch |-> !cmdLatch && !chipSelN && readStrobeN)
        else $error("address cycle pins wrong");
    AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        !writeStrobeN && cmdLatch |-> ioOut[15:8] == 8'h00 && !ioOeN)
        else $error("upper byte not zero in command");
    AST_DIN_WP: assert property (@(posedge mclk) disable iff (!rst_n)
        !writeStrobeN && !cmdLatch && !addrLatch |-> writeProtN)
        else $error("data input with write protect low");
    AST_READ_WE: assert property (@(posedge mclk) disable iff (!rst_n)
        !readStrobeN |-> writeStrobeN && ioOeN && !chipSelN)
        else $error("read strobe low while writing");
    AST_WE_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(writeStrobeN) |-> !writeStrobeN ##1 !writeStrobeN ##1 writeStrobeN)
        else $error("write pulse width wrong");
    AST_BUSY_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_BUSY |-> writeStrobeN && readStrobeN)
        else $error("strobe moved while busy");
    AST_DEFINED: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(writeStrobeN) && cmdLatch |->
        nand_host_pkg::isDefined(ioOut[7:0]))
        else $error("undefined command issued");
    AST_PARTIAL: assert property (@(posedge mclk) disable iff (!rst_n)
        progCnt_reg <= 3'(nand_host_pkg::PARTIAL_PROGRAM_LIMIT))
        else $error("partial program limit exceeded");
    AST_WP_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        !writeStrobeN && cmdLatch && nand_host_pkg::isWriteMode(ioOut[7:0])
        |-> writeProtN)
        else $error("write-mode command with protect low");
    AST_BUSY_END: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_BUSY && rbLevel |=> respValid && state_reg == S_IDLE)
        else $error("ready not reported");

endmodule

// ===== include/nand_host_pkg.sv
package nand_host_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;

    localparam int T_CLS_NS  = 10;
    localparam int T_WP_NS   = 12;
    localparam int T_WH_NS   = 10;
    localparam int T_WB_NS   = 60;
    localparam int T_WHR_NS  = 80;
    localparam int T_REA_NS  = 22;
    localparam int T_REH_NS  = 10;
    localparam int T_R_NS    = 25000;
    localparam int T_RCBSY_NS = 25000;
    localparam int T_PROG_NS = 600000;
    localparam int T_CBSY_NS = 600000;
    localparam int T_ERASE_NS = 3500000;
    localparam int T_FEAT_NS = 1000;
    localparam int T_RST_NS  = 500000;

    function automatic int cycMin(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cycMax(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC = cycMin(T_CLS_NS);
    localparam int WP_CYC    = cycMin(T_WP_NS);
    localparam int WH_CYC    = cycMin(T_WH_NS);
    localparam int WB_CYC    = cycMin(T_WB_NS);
    localparam int WHR_CYC   = cycMin(T_WHR_NS);
    localparam int REA_CYC   = cycMin(T_REA_NS);
    localparam int REH_CYC   = cycMin(T_REH_NS);
    localparam int RD_CYC    = cycMax(T_R_NS);
    localparam int RCBSY_CYC = cycMax(T_RCBSY_NS);
    localparam int FEAT_CYC  = cycMax(T_FEAT_NS);

    localparam int SYNC_STAGES = 3;
    localparam int CNT_W       = 20;
    localparam int IO_W        = 16;
    localparam int PARTIAL_PROGRAM_LIMIT = 4;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] C_READ1    = 8'h00;
    localparam logic [7:0] C_READ2    = 8'h30;
    localparam logic [7:0] C_RNDIN    = 8'h85;
    localparam logic [7:0] C_RNDOUT1  = 8'h05;
    localparam logic [7:0] C_RNDOUT2  = 8'he0;
    localparam logic [7:0] C_CRDRND   = 8'h31;
    localparam logic [7:0] C_CRDEND   = 8'h3f;
    localparam logic [7:0] C_ID       = 8'h90;
    localparam logic [7:0] C_PARAM    = 8'hec;
    localparam logic [7:0] C_UID      = 8'hed;
    localparam logic [7:0] C_SETFEAT  = 8'hef;
    localparam logic [7:0] C_GETFEAT  = 8'hee;
    localparam logic [7:0] C_RESET    = 8'hff;
    localparam logic [7:0] C_PROG1    = 8'h80;
    localparam logic [7:0] C_PROG2    = 8'h10;
    localparam logic [7:0] C_CPROG2   = 8'h15;
    localparam logic [7:0] C_ERASE1   = 8'h60;
    localparam logic [7:0] C_ERASE2   = 8'hd0;
    localparam logic [7:0] C_STATUS   = 8'h70;
    localparam logic [7:0] C_PROTST   = 8'h7a;

    function automatic logic isDefined(input logic [7:0] c);
        return c inside {C_READ1, C_READ2, C_RNDIN, C_RNDOUT1, C_RNDOUT2,
                         C_CRDRND, C_CRDEND, C_ID, C_PARAM, C_UID,
                         C_SETFEAT, C_GETFEAT, C_RESET, C_PROG1, C_PROG2,
                         C_CPROG2, C_ERASE1, C_ERASE2, C_STATUS, C_PROTST};
    endfunction

    function automatic logic isWriteMode(input logic [7:0] c);
        return c inside {C_PROG1, C_PROG2, C_CPROG2, C_RNDIN,
                         C_ERASE1, C_ERASE2, C_SETFEAT};
    endfunction

    function automatic logic isBusyOk(input logic [7:0] c);
        return c inside {C_RESET, C_STATUS};
    endfunction

    // ****************************************
    // request and answer
    // ****************************************
    typedef enum logic [2:0] {
        K_CMD  = 3'h0,
        K_ADDR = 3'h1,
        K_DIN  = 3'h2,
        K_DOUT = 3'h3
    } kind_e;

    typedef struct packed {
        kind_e             kind;
        logic [IO_W-1:0]   data;
    } req_s;

    typedef struct packed {
        logic [IO_W-1:0]   data;
        logic              refused;
        logic              timeout;
    } resp_s;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);

    // ****************************************
    // three-stage catch per bit
    // ****************************************
    // stage 1 feeds only stage 2; level moves once stages 2 and 3 agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    s1_reg  <= 1'b1;
                    s2_reg  <= 1'b1;
                    s3_reg  <= 1'b1;
                    lvl_reg <= 1'b1;
                end else begin
                    s1_reg <= pinIn[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign level[i] = lvl_reg;
        end
    endgenerate

endmodule

// ===== verif/nand_dev_model.sv
`timescale 1ns/100ps
// ****************************************
// flash device model
// ****************************************
module nand_dev_model (
    input  wire logic        chipSelN,
    input  wire logic        cmdLatch,
    input  wire logic        addrLatch,
    input  wire logic        writeStrobeN,
    input  wire logic        readStrobeN,
    input  wire logic        writeProtN,
    input  wire logic [15:0] ioOut,
    input  wire logic        slow,
    input  wire logic        prot,
    output logic [15:0]      ioIn,
    output logic             readyBusyN
);
    logic [7:0]  lastCmd = 8'h00;
    logic [7:0]  c;
    logic [15:0] col     = 16'h0000;
    int          nCmd    = 0;
    realtime     busyEnd = 0;
    logic        failSt  = 1'b0;

    initial ioIn = 16'h0000;
    initial readyBusyN = 1'b1;
    always #4 if ($realtime >= busyEnd) readyBusyN = 1'b1;

    always @(posedge writeStrobeN) begin
        c = ioOut[7:0];
        if (!chipSelN && readStrobeN && cmdLatch && !addrLatch
            && (readyBusyN || c inside {8'hff, 8'h70})
            && ioOut[15:8] == 8'h00
            && (writeProtN || !(c inside {8'h80, 8'h10, 8'h60}))) begin
            lastCmd = c;
            nCmd++;
            col = 16'h0000;
            // one busy figure per speed setting (400 or 4000 ns) for every launch not on a locked target keeps the model small
            if (c inside {8'h30, 8'h31, 8'h3f, 8'h10, 8'h15,
                          8'hd0, 8'hef, 8'hee, 8'hff}) begin
                readyBusyN = 1'b0;
                busyEnd = $realtime + (slow ? 4000 : 400);
                failSt = 1'b0;
                // a locked target stays busy 1000 ns and reads back as failed
                if (prot && c inside {8'h10, 8'h15, 8'hd0}) begin
                    busyEnd = $realtime + 1000;
                    failSt = 1'b1;
                end
            end
        end
    end

    always @(negedge readStrobeN)
        if (!chipSelN && !cmdLatch && !addrLatch && writeStrobeN) begin
            case (lastCmd)
                8'h70: ioIn = failSt ? 16'h0060
                                     : {8'h00, readyBusyN, 7'h60};
                8'h7a: ioIn = 16'h0005;
                8'hec: ioIn = 16'h4f00 + col;
                8'hed: ioIn = 16'hd100 + col;
                default: ioIn = 16'h5a00 + col;
            endcase
            col++;
        end

    // released bus shows the inverse so a late sample cannot pass
    always @(posedge readStrobeN) ioIn = ~ioIn;
endmodule

// ===== verif/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 reqValid = 1'b0;
    logic                 writeAllow = 1'b1;
    logic                 slow = 1'b0;
    logic                 prot = 1'b0;
    nand_host_pkg::req_s  req = '0;
    nand_host_pkg::resp_s resp;
    nand_host_pkg::resp_s got;
    logic                 reqReady, respValid, chipSelN, cmdLatch;
    logic                 addrLatch, writeStrobeN, readStrobeN;
    logic                 writeProtN, ioOeN, readyBusyN;
    logic [15:0]          ioOut, ioIn;
    int                   failures = 0;
    int                   n_checks = 0;

    always #4 mclk = ~mclk;

    nand_host_ctrl #(.PROG_WAIT(200), .CPROG_WAIT(200), .ERASE_WAIT(200),
        .RST_WAIT(200)) DUT (.mclk, .rst_n, .reqValid, .req, .reqReady,
        .respValid, .resp, .writeAllow, .chipSelN, .cmdLatch, .addrLatch,
        .writeStrobeN, .readStrobeN, .writeProtN, .ioOut, .ioOeN, .ioIn,
        .readyBusyN);

    nand_dev_model dev (.chipSelN, .cmdLatch, .addrLatch, .writeStrobeN,
        .readStrobeN, .writeProtN, .ioOut, .slow, .prot, .ioIn, .readyBusyN);

    task automatic xfer(input nand_host_pkg::kind_e k, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk) #1;
        reqValid = 1'b1;
        req.kind = k;
        req.data = d;
        do begin @(posedge mclk) #1; n++; end while (!reqReady && n < 100);
        reqValid = 1'b0;
        while (!respValid && n < 3000) begin @(posedge mclk) #1; n++; end
        if (n >= 3000) begin
            failures++;
            $display("[ERR] %0t no answer", $time);
        end
        got = resp;
    endtask

    task automatic cmd(input logic [7:0] c);
        xfer(nand_host_pkg::K_CMD, {8'h00, c});
    endtask

    task automatic t_status();
        cmd(8'h70);
        `CHK(got.refused, 1'b0)
        `CHK(dev.lastCmd, 8'h70)
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h00e0)
        // chip select lifts one cycle after the answer pulse
        @(posedge mclk) #1;
        `CHK(chipSelN, 1'b1)
        $display("status test done");
    endtask

    task automatic t_undef();
        int n;
        n = dev.nCmd;
        cmd(8'h01);
        `CHK(got.refused, 1'b1)
        `CHK(dev.nCmd, n)
        $display("undefined code test done");
    endtask

    task automatic t_read();
        cmd(8'h00);
        repeat (4) xfer(nand_host_pkg::K_ADDR, 16'h0000);
        cmd(8'h30);
        `CHK(got.timeout, 1'b0)
        `CHK(dev.lastCmd, 8'h30)
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h5a00)
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h5a01)
        $display("page read test done");
    endtask

    task automatic t_busy();
        slow = 1'b1;
        cmd(8'hef);
        `CHK(got.timeout, 1'b1)
        cmd(8'h90);
        `CHK(got.refused, 1'b1)
        cmd(8'h70);
        `CHK(got.refused, 1'b0)
        slow = 1'b0;
        cmd(8'hff);
        `CHK(got.timeout, 1'b0)
        `CHK(readyBusyN, 1'b1)
        $display("busy test done");
    endtask

    task automatic t_prog();
        cmd(8'h80);
        repeat (4) xfer(nand_host_pkg::K_ADDR, 16'h0000);
        xfer(nand_host_pkg::K_DIN, 16'h1234);
        cmd(8'h10);
        `CHK(got.timeout, 1'b0)
        `CHK(dev.lastCmd, 8'h10)
        writeAllow = 1'b0;
        cmd(8'h60);
        `CHK(got.refused, 1'b1)
        `CHK(writeProtN, 1'b0)
        writeAllow = 1'b1;
        $display("program test done");
    endtask

    task automatic t_cache();
        cmd(8'h00);
        cmd(8'h31);
        `CHK(got.timeout, 1'b0)
        cmd(8'h3f);
        `CHK(got.timeout, 1'b0)
        `CHK(dev.lastCmd, 8'h3f)
        cmd(8'hee);
        `CHK(got.timeout, 1'b0)
        cmd(8'h80);
        xfer(nand_host_pkg::K_DIN, 16'h0055);
        cmd(8'h15);
        `CHK(got.timeout, 1'b0)
        $display("cache test done");
    endtask

    task automatic t_pages();
        cmd(8'hec);
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h4f00)
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h4f01)
        cmd(8'hed);
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'hd100)
        cmd(8'h7a);
        xfer(nand_host_pkg::K_ADDR, 16'h0000);
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h0005)
        $display("page select test done");
    endtask

    task automatic t_protect();
        prot = 1'b1;
        cmd(8'h60);
        cmd(8'hd0);
        `CHK(got.timeout, 1'b0)
        cmd(8'h70);
        xfer(nand_host_pkg::K_DOUT, 16'h0000);
        `CHK(got.data, 16'h0060)
        cmd(8'h80);
        cmd(8'h10);
        `CHK(got.timeout, 1'b0)
        prot = 1'b0;
        repeat (3) begin
            cmd(8'h80);
            cmd(8'h10);
        end
        `CHK(got.refused, 1'b0)
        cmd(8'h80);
        cmd(8'h10);
        `CHK(got.refused, 1'b1)
        $display("protect test done");
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        t_status();
        t_undef();
        t_read();
        t_busy();
        t_prog();
        t_cache();
        t_pages();
        t_protect();
        conclude();
    end

    initial begin
        #400000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule
